//--- common/scz_regs.svh
// offsets, field positions, reset values and timing counts of the stroke counter
// assumes a 25 MHz pclk and a 32-bit apb with word-aligned registers
`ifndef SCZ_REGS_SVH
`define SCZ_REGS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SCZ_CLK_KHZ 25000
`define SCZ_SAMPLE_US 2000
`define SCZ_SAMPLE_CYCLES ((`SCZ_SAMPLE_US * `SCZ_CLK_KHZ) / 1000)

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SCZ_OFF_STATUS 8'h00
`define SCZ_OFF_POS 8'h04
`define SCZ_OFF_REF 8'h08
`define SCZ_OFF_TOL 8'h0C
`define SCZ_OFF_TEMP 8'h10
`define SCZ_OFF_HUM 8'h14
`define SCZ_OFF_HUM_EFF 8'h18
`define SCZ_OFF_CTRL 8'h1C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SCZ_BIT_ZONE_EN 0
`define SCZ_BIT_TEMP_EN 1
`define SCZ_BIT_HUM_EN 2
`define SCZ_BIT_ZONE_OUT 3
`define SCZ_BIT_DISP_OFF 4
`define SCZ_BIT_STEP 8

// ----------------------------------------------------------------
// reset values, 0.01 mm for zone, 0.1 unit for temp and humidity
// ----------------------------------------------------------------
`define SCZ_REF_INIT 16'h03E8
`define SCZ_TOL_INIT 16'h0005
`define SCZ_TEMP_INIT 16'h0118
`define SCZ_HUM_INIT 16'h0258
`define SCZ_HUM_AUTO 16'h0000

`endif

//--- common/scz_pkg.sv
// types shared by the stroke counter modules
// assumes scz_regs.svh holds the numbers
package scz_pkg;

	// ----------------------------------------------------------------
	// settings steps
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		st_idle,
		st_zone_en,
		st_zone_ref,
		st_zone_tol,
		st_temp_en,
		st_temp_val,
		st_hum_en,
		st_hum_val
	} scz_step_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic up;
		logic down;
		logic mode;
	} scz_keys_t;

	typedef struct packed {
		logic red;
		logic green;
		logic zone;
		logic temp;
		logic hum;
	} scz_lamps_t;

	typedef struct packed {
		logic a;
		logic b;
	} scz_quad_t;

	// ----------------------------------------------------------------
	// top state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] pos;
		logic disp_off;
		logic zone_out;
		logic [31:0] tick_cnt;
		logic [15:0] ref_val;
		logic [15:0] tol_val;
		logic [15:0] temp_val;
		logic [15:0] hum_val;
		logic zone_en;
		logic temp_en;
		logic hum_en;
		scz_step_t step;
		scz_keys_t key_prev;
		scz_lamps_t lamps;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} scz_state_t;

endpackage

//--- hw/scz_quad.sv
// two-phase count decoder, one step per phase edge
// assumes phase inputs synchronous to pclk
module scz_quad
	import scz_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire scz_quad_t phase,
	output logic step_up,
	output logic step_dn
);

	scz_quad_t prev_q;
	scz_quad_t prev_d;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	always_comb begin
		prev_d = phase;
		step_up = 1'b0;
		step_dn = 1'b0;
		unique case ({prev_q.a, prev_q.b, phase.a, phase.b})
			4'b0010, 4'b1011, 4'b1101, 4'b0100: step_up = 1'b1;
			4'b0001, 4'b0111, 4'b1110, 4'b1000: step_dn = 1'b1;
			default: ;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= '0;
		end else begin
			prev_q <= prev_d;
		end
	end

endmodule // scz_quad

//--- hw/scz_top.sv
// stroke counter: position count, 2 ms zone compare, clear and settings keys
// assumes synchronous key, phase and clear inputs and an apb master on pclk
//
// Operation
// - zone output on inside reference plus/minus allowed
// - sample count for compare every 2 ms
// - zone evaluated only at sample instants
// - show off until clear, then zero
// - clear from key chord, input or serial
// - red lamp lit while switch output on
// - green lamp lit during settings steps
// - up/down step value, mode advances step
// - zone step toggles zone checking, lamp
// - reference starts 10.00, edited after zone step
// - allowed value starts 0.05, signed entry
// - mode after allowed goes to temperature
// - temperature step toggles correction, lamp
// - temperature starts 28.0, mode to humidity
// - humidity step toggles correction, lamp
// - humidity starts 60.0, keys adjust it
// - humidity 00.0 selects external unit value
// - zone result on first output line
`include "scz_regs.svh"

module scz_top
	import scz_pkg::*;
#(
	parameter int unsigned SAMPLE_CYCLES = `SCZ_SAMPLE_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire scz_quad_t phase,
	input wire scz_keys_t keys,
	input wire logic external_clear_input,
	input wire logic serial_clear_command,
	input wire logic [15:0] hum_unit_value,
	output logic zone_out,
	output scz_lamps_t lamps,
	output logic display_off
);

	scz_state_t st_q;
	scz_state_t st_d;
	logic step_up;
	logic step_dn;
	scz_keys_t rise;
	logic chord;
	logic clr;
	logic kup;
	logic kdn;
	logic tick;
	logic band_w;
	logic [15:0] hum_eff;
	logic wr_en;
	logic addr_ok;
	logic [31:0] rd_w;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic in_band(input logic [31:0] p, input logic [15:0] r,
		input logic [15:0] t);
		logic signed [33:0] ps;
		logic signed [33:0] rs;
		logic signed [33:0] ts;
		logic signed [33:0] mag;
		ps = {{2{p[31]}}, p};
		rs = {{18{r[15]}}, r};
		ts = {{18{t[15]}}, t};
		mag = (ts < 0) ? -ts : ts;
		return (ps >= rs - mag) && (ps <= rs + mag);
	endfunction

	function automatic logic [15:0] step_val(input logic [15:0] v, input logic [15:0] keep,
		input logic up, input logic dn);
		logic [15:0] r;
		r = keep;
		if (up) begin
			r = v + 16'h0001;
		end else if (dn) begin
			r = v - 16'h0001;
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// count decoder
	// ----------------------------------------------------------------
	scz_quad u_quad (
		.pclk(pclk),
		.presetn(presetn),
		.phase(phase),
		.step_up(step_up),
		.step_dn(step_dn)
	);

	// ----------------------------------------------------------------
	// combinational terms
	// ----------------------------------------------------------------
	assign rise = keys & ~st_q.key_prev;
	assign chord = keys.up && keys.down && (rise.up || rise.down);
	assign clr = chord || external_clear_input || serial_clear_command;
	assign kup = rise.up && !keys.down;
	assign kdn = rise.down && !keys.up;
	assign tick = (st_q.tick_cnt == 32'(SAMPLE_CYCLES - 1));
	assign band_w = in_band(st_q.pos, st_q.ref_val, st_q.tol_val);
	assign hum_eff = (st_q.hum_val == `SCZ_HUM_AUTO) ? hum_unit_value : st_q.hum_val;
	assign wr_en = psel && penable && st_q.pready && pwrite && !st_q.pslverr;

	always_comb begin
		addr_ok = 1'b1;
		rd_w = '0;
		unique case (paddr)
			`SCZ_OFF_STATUS: begin
				rd_w[`SCZ_BIT_ZONE_EN] = st_q.zone_en;
				rd_w[`SCZ_BIT_TEMP_EN] = st_q.temp_en;
				rd_w[`SCZ_BIT_HUM_EN] = st_q.hum_en;
				rd_w[`SCZ_BIT_ZONE_OUT] = st_q.zone_out;
				rd_w[`SCZ_BIT_DISP_OFF] = st_q.disp_off;
				rd_w[`SCZ_BIT_STEP +: 3] = st_q.step;
			end
			`SCZ_OFF_POS: rd_w = st_q.pos;
			`SCZ_OFF_REF: rd_w = {{16{st_q.ref_val[15]}}, st_q.ref_val};
			`SCZ_OFF_TOL: rd_w = {{16{st_q.tol_val[15]}}, st_q.tol_val};
			`SCZ_OFF_TEMP: rd_w = {16'h0000, st_q.temp_val};
			`SCZ_OFF_HUM: rd_w = {16'h0000, st_q.hum_val};
			`SCZ_OFF_HUM_EFF: rd_w = {16'h0000, hum_eff};
			`SCZ_OFF_CTRL: begin
				rd_w[`SCZ_BIT_ZONE_EN] = st_q.zone_en;
				rd_w[`SCZ_BIT_TEMP_EN] = st_q.temp_en;
				rd_w[`SCZ_BIT_HUM_EN] = st_q.hum_en;
			end
			default: addr_ok = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.key_prev = keys;
		st_d.pready = psel && !penable;
		st_d.pslverr = psel && !penable && !addr_ok;
		if (psel && !penable) begin
			st_d.prdata = addr_ok ? rd_w : 32'h0000_0000;
		end
		// software writes, keys below take over on a collision
		if (wr_en) begin
			unique case (paddr)
				`SCZ_OFF_REF: st_d.ref_val = pwdata[15:0];
				`SCZ_OFF_TOL: st_d.tol_val = pwdata[15:0];
				`SCZ_OFF_TEMP: st_d.temp_val = pwdata[15:0];
				`SCZ_OFF_HUM: st_d.hum_val = pwdata[15:0];
				`SCZ_OFF_CTRL: begin
					st_d.zone_en = pwdata[`SCZ_BIT_ZONE_EN];
					st_d.temp_en = pwdata[`SCZ_BIT_TEMP_EN];
					st_d.hum_en = pwdata[`SCZ_BIT_HUM_EN];
				end
				default: ;
			endcase
		end

		// count, held at zero on clear
		if (clr) begin
			st_d.pos = 32'h0000_0000;
			// first clear leaves the off display
			st_d.disp_off = 1'b0;
		end else if (!st_q.disp_off && step_up) begin
			st_d.pos = st_q.pos + 32'h0000_0001;
		end else if (!st_q.disp_off && step_dn) begin
			st_d.pos = st_q.pos - 32'h0000_0001;
		end

		st_d.tick_cnt = tick ? 32'h0000_0000 : st_q.tick_cnt + 32'h0000_0001;

		// band compare at sample instants only
		if (tick) begin
			st_d.zone_out = st_q.zone_en && !st_q.disp_off && band_w;
		end

		unique case (st_q.step)
			st_idle: begin
				if (rise.mode) begin
					st_d.step = st_zone_en;
				end
			end
			st_zone_en: begin
				if (kup || kdn) begin
					st_d.zone_en = !st_q.zone_en;
				end
				if (rise.mode) begin
					st_d.step = st_zone_ref;
				end
			end
			st_zone_ref: begin
				st_d.ref_val = step_val(st_q.ref_val, st_d.ref_val, kup, kdn);
				if (rise.mode) begin
					st_d.step = st_zone_tol;
				end
			end
			st_zone_tol: begin
				st_d.tol_val = step_val(st_q.tol_val, st_d.tol_val, kup, kdn);
				if (rise.mode) begin
					st_d.step = st_temp_en;
				end
			end
			st_temp_en: begin
				if (kup || kdn) begin
					st_d.temp_en = !st_q.temp_en;
				end
				if (rise.mode) begin
					st_d.step = st_temp_val;
				end
			end
			st_temp_val: begin
				st_d.temp_val = step_val(st_q.temp_val, st_d.temp_val, kup, kdn);
				if (rise.mode) begin
					st_d.step = st_hum_en;
				end
			end
			st_hum_en: begin
				if (kup || kdn) begin
					st_d.hum_en = !st_q.hum_en;
				end
				if (rise.mode) begin
					st_d.step = st_hum_val;
				end
			end
			st_hum_val: begin
				st_d.hum_val = step_val(st_q.hum_val, st_d.hum_val, kup, kdn);
				if (rise.mode) begin
					st_d.step = st_idle;
				end
			end
		endcase

		st_d.lamps.red = st_d.zone_out;
		st_d.lamps.green = (st_d.step != st_idle);
		st_d.lamps.zone = st_d.zone_en;
		st_d.lamps.temp = st_d.temp_en;
		st_d.lamps.hum = st_d.hum_en;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
			st_q.disp_off <= 1'b1;
			st_q.ref_val <= `SCZ_REF_INIT;
			st_q.tol_val <= `SCZ_TOL_INIT;
			st_q.temp_val <= `SCZ_TEMP_INIT;
			st_q.hum_val <= `SCZ_HUM_INIT;
			st_q.step <= st_idle;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata = st_q.prdata;
	assign pready = st_q.pready;
	assign pslverr = st_q.pslverr;
	// zone result on output line one
	assign zone_out = st_q.zone_out;
	assign lamps = st_q.lamps;
	assign display_off = st_q.disp_off;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	zone_band_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		tick && st_q.zone_en && !st_q.disp_off |=> zone_out == $past(band_w))
		else $error("zone output disagrees with band");

	sample_period_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		tick |=> st_q.tick_cnt == 32'h0000_0000 && !tick)
		else $error("sample divider off");

	sample_hold_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!tick |=> $stable(zone_out))
		else $error("zone output moved between samples");

	off_until_clear_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		display_off && !clr |=> display_off && st_q.pos == 32'h0000_0000)
		else $error("off display left without clear");

	clear_zero_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(external_clear_input || serial_clear_command || chord) |=>
		st_q.pos == 32'h0000_0000 && !display_off)
		else $error("clear not taken");

	red_lamp_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(zone_out) |-> lamps.red ##1 lamps.red == zone_out)
		else $error("red lamp not tracking output");

	green_lamp_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_q.step == st_idle && rise.mode |=> lamps.green)
		else $error("green lamp not lit in settings");

	ref_step_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_q.step == st_zone_ref && kup |=> st_q.ref_val == $past(st_q.ref_val) + 16'h0001)
		else $error("reference did not step up");

	zone_toggle_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_q.step == st_zone_en && (kup || kdn) |=> st_q.zone_en != $past(st_q.zone_en)
		##0 lamps.zone == st_q.zone_en)
		else $error("zone enable not toggled");

	tol_to_temp_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_q.step == st_zone_tol && rise.mode |=> st_q.step == st_temp_en)
		else $error("allowed step did not advance");

	temp_to_hum_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_q.step == st_temp_val && rise.mode |=> st_q.step == st_hum_en)
		else $error("temperature step did not advance");

	hum_auto_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_q.hum_val == `SCZ_HUM_AUTO |-> hum_eff == hum_unit_value)
		else $error("auto humidity not selected");

endmodule // scz_top

//--- verif/scz_head_model.sv
// sensor head model: two-phase count outputs stepped on request
// assumes at most one step request per pclk edge, driven by the bench
module scz_head_model
	import scz_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic fwd,
	input wire logic rev,
	output scz_quad_t phase
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [1:0] idx_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_q <= 2'h0;
		end else if (fwd) begin
			idx_q <= idx_q + 2'h1;
		end else if (rev) begin
			idx_q <= idx_q - 2'h1;
		end
	end

	assign phase.a = idx_q[1] ^ idx_q[0];
	assign phase.b = idx_q[1];
endmodule // scz_head_model

//--- verif/tb_stroke_counter_zone_settings.sv
// bench for the stroke counter: apb, clears, settings keys and zone compare
// assumes scz_top with a short sample period and the sensor head model
`include "scz_regs.svh"
module tb_stroke_counter_zone_settings
	import scz_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;

	localparam int SAMP = 20;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic fwd, rev, ext_clr, ser_clr, zone_out, display_off;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] hum_unit;
	scz_quad_t phase;
	scz_keys_t keys;
	scz_lamps_t lamps;
	int n_errors, check_count, seed, i, tgt, rf, tl, pos_m;

	scz_top #(.SAMPLE_CYCLES(SAMP)) scz_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .phase(phase), .keys(keys),
		.external_clear_input(ext_clr), .serial_clear_command(ser_clr),
		.hum_unit_value(hum_unit), .zone_out(zone_out), .lamps(lamps),
		.display_off(display_off));
	scz_head_model scz_head_model_inst (.pclk(pclk), .presetn(presetn), .fwd(fwd), .rev(rev),
		.phase(phase));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic press(input scz_keys_t k);
		@(posedge pclk);
		keys <= k;
		repeat (2) @(posedge pclk);
		keys <= '0;
		repeat (2) @(posedge pclk);
	endtask

	task automatic move(input int n);
		repeat (n < 0 ? -n : n) begin
			@(posedge pclk);
			fwd <= n > 0;
			rev <= n < 0;
			@(posedge pclk);
			fwd <= 1'b0;
			rev <= 1'b0;
		end
		repeat (3) @(posedge pclk);
		pos_m += n;
	endtask

	task automatic step_is(input logic [2:0] e);
		apb(1'b0, `SCZ_OFF_STATUS, 32'h0000_0000);
		chk({29'h0, rd[10:8]}, {29'h0, e});
	endtask

	function automatic logic zexp(input int p, input int r, input int t);
		int d;
		d = p - r;
		if (d < 0)
			d = -d;
		return d <= t;
	endfunction

	initial begin
		repeat (30000) @(posedge pclk);
		n_errors++;
		$display("[ERR] %0t watchdog ran out", $time);
		stop_test();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, fwd, rev, ext_clr, ser_clr} = '0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		keys = '0;
		hum_unit = 16'h0000;
		seed = 72103;
		pos_m = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		chk(display_off, 1'b1);
		apb(1'b0, `SCZ_OFF_REF, 32'h0000_0000);
		chk(rd, 32'h0000_03e8);
		apb(1'b0, `SCZ_OFF_TOL, 32'h0000_0000);
		chk(rd, 32'h0000_0005);
		apb(1'b0, `SCZ_OFF_TEMP, 32'h0000_0000);
		chk(rd, 32'h0000_0118);
		apb(1'b0, `SCZ_OFF_HUM, 32'h0000_0000);
		chk(rd, 32'h0000_0258);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk({31'h0, er}, 32'h0000_0001);
		apb(1'b0, `SCZ_OFF_STATUS, 32'h0000_0000);
		chk({31'h0, rd[`SCZ_BIT_DISP_OFF]}, 32'h0000_0001);
		apb(1'b1, `SCZ_OFF_POS, 32'h0000_1234);
		move(3);
		pos_m = 0;
		apb(1'b0, `SCZ_OFF_POS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		$display("test reset done");

		for (i = 0; i < 3; i++) begin
			@(posedge pclk);
			case (i)
				0: ext_clr <= 1'b1;
				1: ser_clr <= 1'b1;
				default: keys <= '{up: 1'b1, down: 1'b1, mode: 1'b0};
			endcase
			@(posedge pclk);
			ext_clr <= 1'b0;
			ser_clr <= 1'b0;
			keys <= '0;
			repeat (2) @(posedge pclk);
			pos_m = 0;
			chk(display_off, 1'b0);
			apb(1'b0, `SCZ_OFF_POS, 32'h0000_0000);
			chk(rd, 32'h0000_0000);
			tgt = 1 + $unsigned($random(seed)) % 8;
			move(i == 1 ? -tgt : tgt);
			apb(1'b0, `SCZ_OFF_POS, 32'h0000_0000);
			chk(rd, 32'(pos_m));
		end
		$display("test clear done");

		press('{up: 1'b0, down: 1'b0, mode: 1'b1});
		chk(lamps.green, 1'b1);
		step_is(3'h1);
		press('{up: 1'b1, down: 1'b0, mode: 1'b0});
		chk(lamps.zone, 1'b1);
		press('{up: 1'b0, down: 1'b0, mode: 1'b1});
		step_is(3'h2);
		tgt = 1 + $unsigned($random(seed)) % 4;
		repeat (tgt) press('{up: 1'b1, down: 1'b0, mode: 1'b0});
		apb(1'b0, `SCZ_OFF_REF, 32'h0000_0000);
		chk(rd, 32'h0000_03e8 + 32'(tgt));
		press('{up: 1'b0, down: 1'b0, mode: 1'b1});
		step_is(3'h3);
		repeat (6) press('{up: 1'b0, down: 1'b1, mode: 1'b0});
		apb(1'b0, `SCZ_OFF_TOL, 32'h0000_0000);
		chk(rd, 32'hffff_ffff);
		press('{up: 1'b0, down: 1'b0, mode: 1'b1});
		step_is(3'h4);
		press('{up: 1'b0, down: 1'b1, mode: 1'b0});
		chk(lamps.temp, 1'b1);
		press('{up: 1'b0, down: 1'b0, mode: 1'b1});
		press('{up: 1'b1, down: 1'b0, mode: 1'b0});
		apb(1'b0, `SCZ_OFF_TEMP, 32'h0000_0000);
		chk(rd, 32'h0000_0119);
		press('{up: 1'b0, down: 1'b0, mode: 1'b1});
		step_is(3'h6);
		press('{up: 1'b1, down: 1'b0, mode: 1'b0});
		chk(lamps.hum, 1'b1);
		press('{up: 1'b0, down: 1'b0, mode: 1'b1});
		press('{up: 1'b0, down: 1'b1, mode: 1'b0});
		apb(1'b0, `SCZ_OFF_HUM_EFF, 32'h0000_0000);
		chk(rd, 32'h0000_0257);
		press('{up: 1'b0, down: 1'b0, mode: 1'b1});
		chk(lamps.green, 1'b0);
		hum_unit <= 16'($unsigned($random(seed)) % 1000 + 1);
		apb(1'b1, `SCZ_OFF_HUM, 32'h0000_0000);
		apb(1'b0, `SCZ_OFF_HUM_EFF, 32'h0000_0000);
		chk(rd, {16'h0000, hum_unit});
		$display("test settings done");

		rf = $unsigned($random(seed)) % 30 + 10;
		tl = 1 + $unsigned($random(seed)) % 4;
		apb(1'b1, `SCZ_OFF_REF, 32'(rf));
		apb(1'b1, `SCZ_OFF_TOL, 32'(tl));
		for (i = 0; i < 7; i++) begin
			case (i)
				0: tgt = rf + tl;
				1: tgt = rf + tl + 1;
				2: tgt = rf - tl;
				3: tgt = rf - tl - 1;
				default: tgt = $unsigned($random(seed)) % 50;
			endcase
			move(tgt - pos_m);
			repeat (SAMP + 3) @(posedge pclk);
			chk(zone_out, zexp(pos_m, rf, tl));
			chk(lamps.red, zexp(pos_m, rf, tl));
			apb(1'b0, `SCZ_OFF_STATUS, 32'h0000_0000);
			chk({31'h0, rd[`SCZ_BIT_ZONE_OUT]}, {31'h0, zexp(pos_m, rf, tl)});
		end
		move(rf - pos_m);
		apb(1'b1, `SCZ_OFF_CTRL, 32'h0000_0000);
		repeat (SAMP + 3) @(posedge pclk);
		chk(zone_out, 1'b0);
		chk(lamps.zone, 1'b0);
		$display("test zone done");

		@(posedge pclk);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(display_off, 1'b1);
		chk(zone_out, 1'b0);
		chk(lamps.zone, 1'b0);
		apb(1'b0, `SCZ_OFF_REF, 32'h0000_0000);
		chk(rd, 32'h0000_03e8);
		$display("test reset again done");
		stop_test();
	end
endmodule // tb_stroke_counter_zone_settings
